/* vc_resource_config_regs.v */
// Channel resource configuration registers of one switch port:
// channel 0 control and status, channel 1 capability.
// Assumes a single-cycle register port on the core clock; negotiation
// state arrives from the link side and is synchronised here.
//
// Contract
// [RULE_01] Each map bit set carries that traffic class on channel 0.
// [RULE_02] Map resets to all classes; EEPROM autoload may replace it.
// [RULE_03] Writing one to table load applies the table; reads as zero.
// [RULE_04] Select keeps supported scheme codes only; others become default.
// [RULE_05] Channel identifier is read-only and always zero.
// [RULE_06] Channel enable bit gates the channel; resets to one.
// [RULE_07] Table status sets whenever software writes a table entry.
// [RULE_08] Table status clears when loading after a load request finishes.
// [RULE_09] Negotiation pending reads one while negotiating; resets to zero.
// [RULE_10] Capability field is 19h with channel 1 present, else zero.
// [RULE_11] Weighted tables have 128 phases; time-based only on channel 1.
// [RULE_12] Advanced-switching-only and reject snoop bits read zero.
// [RULE_13] Slots field resets 7Fh if present, else zero; autoload overrides.
// [RULE_14] Table offset is eight sixteen-byte units if present, else zero.
// [RULE_15] Reserved bits read zero and ignore writes.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "vc_resource_defs.vh"

module vc_resource_config_regs #(
  parameter ADDR_W = 12,
  parameter PHASE_IDX_W = 7
) (
  input wire I_CORE_CLK,
  input wire I_SRST,
  input wire [ADDR_W-1:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  input wire I_CHANNEL1_PRESENT,
  input wire I_AUTOLOAD_VALID,
  input wire [7:0] I_AUTOLOAD_MAP,
  input wire [6:0] I_AUTOLOAD_SLOTS,
  input wire I_TABLE_ENTRY_WR,
  input wire I_NEGOTIATING,
  output reg [7:0] O_CLASS_TO_CHANNEL_MAP,
  output reg [2:0] O_ARB_SELECT,
  output reg O_CHANNEL_ENABLE,
  output reg O_TABLE_APPLY,
  output wire O_TABLE_BUSY,
  output wire O_PHASE_STROBE,
  output wire [PHASE_IDX_W-1:0] O_PHASE_INDEX
);

  // Access decode
  wire sel_control;
  wire sel_status;
  wire sel_capability;
  wire wr_control;
  wire load_write;

  assign sel_control = (I_ADDR == `OFS_CH0_CONTROL);
  assign sel_status = (I_ADDR == `OFS_CH0_STATUS);
  assign sel_capability = (I_ADDR == `OFS_CH1_CAPABILITY);
  assign wr_control = I_WR && sel_control;
  assign load_write = wr_control && I_WDATA[`CTL_TABLE_LOAD_BIT];

  // Channel 0 control state
  reg [7:0] map_reg;
  reg [7:0] map_next;
  reg [2:0] arb_sel_reg;
  reg [2:0] arb_sel_next;
  reg enable_reg;
  reg enable_next;
  reg load_req_reg;
  wire [2:0] arb_sel_filtered;

  // Channel 1 capability state, captured while reset is held
  reg [7:0] arb_cap_reg;
  reg [6:0] slots_reg;
  reg [6:0] slots_next;
  reg [7:0] table_ofs_reg;

  // Negotiation synchroniser
  reg negotiating_meta_reg;
  reg negotiating_reg;

  // Read path
  reg [31:0] read_word;
  reg [31:0] rdata_next;

  wire table_status;

  arb_select_filter #(
    .ALLOW_TIME_BASED(0)
  ) u_arb_select_filter (
    .i_code(I_WDATA[`CTL_ARB_SEL_MSB:`CTL_ARB_SEL_LSB]),
    .o_code(arb_sel_filtered)
  );

  arb_table_loader #(
    .PHASES(`ARB_PHASES),
    .IDX_W(PHASE_IDX_W)
  ) u_arb_table_loader (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_entry_wr(I_TABLE_ENTRY_WR),
    .i_load_req(load_req_reg),
    .o_status(table_status),
    .o_busy(O_TABLE_BUSY),
    .o_phase_strobe(O_PHASE_STROBE),
    .o_phase_index(O_PHASE_INDEX)
  );

  // Control next values; software write wins over a same-cycle autoload
  always @* begin
    map_next = map_reg;
    arb_sel_next = arb_sel_reg;
    enable_next = enable_reg;
    if (I_AUTOLOAD_VALID) begin
      map_next = I_AUTOLOAD_MAP; // see [RULE_02]
    end
    if (wr_control) begin
      map_next = I_WDATA[`CTL_MAP_MSB:`CTL_MAP_LSB]; // see [RULE_01]
      arb_sel_next = arb_sel_filtered; // see [RULE_04]
      enable_next = I_WDATA[`CTL_ENABLE_BIT]; // see [RULE_06]
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      map_reg <= `RST_MAP; // see [RULE_02]
      arb_sel_reg <= `RST_ARB_SEL;
      enable_reg <= `RST_ENABLE; // see [RULE_06]
      load_req_reg <= 1'b0;
    end else begin
      map_reg <= map_next;
      arb_sel_reg <= arb_sel_next;
      enable_reg <= enable_next;
      // Self-clearing; the bit is never stored for reads
      load_req_reg <= load_write; // see [RULE_03]
    end
  end

  // Capability values follow channel 1 presence at reset
  always @* begin
    slots_next = slots_reg;
    if (I_AUTOLOAD_VALID) begin
      slots_next = I_AUTOLOAD_SLOTS; // see [RULE_13]
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      if (I_CHANNEL1_PRESENT) begin
        arb_cap_reg <= `RST_ARB_CAP_PRESENT; // see [RULE_10]
        slots_reg <= `RST_SLOTS_PRESENT; // see [RULE_13]
        table_ofs_reg <= `RST_TABLE_OFS_PRESENT; // see [RULE_14]
      end else begin
        arb_cap_reg <= `RST_ARB_CAP_ABSENT; // see [RULE_10]
        slots_reg <= `RST_SLOTS_ABSENT; // see [RULE_13]
        table_ofs_reg <= `RST_TABLE_OFS_ABSENT; // see [RULE_14]
      end
    end else begin
      slots_reg <= slots_next;
    end
  end

  // Negotiation state crosses in from the link side
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      negotiating_meta_reg <= 1'b0;
      negotiating_reg <= 1'b0; // see [RULE_09]
    end else begin
      negotiating_meta_reg <= I_NEGOTIATING;
      negotiating_reg <= negotiating_meta_reg; // see [RULE_09]
    end
  end

  // Read word assembly; unlisted bits stay zero
  always @* begin
    read_word = 32'h0000_0000; // see [RULE_15]
    if (sel_control) begin
      read_word[`CTL_MAP_MSB:`CTL_MAP_LSB] = map_reg;
      read_word[`CTL_TABLE_LOAD_BIT] = 1'b0; // see [RULE_03]
      read_word[`CTL_ARB_SEL_MSB:`CTL_ARB_SEL_LSB] = arb_sel_reg;
      read_word[`CTL_CHAN_ID_MSB:`CTL_CHAN_ID_LSB] =
        `RST_CHAN_ID; // see [RULE_05]
      read_word[`CTL_ENABLE_BIT] = enable_reg;
    end else if (sel_status) begin
      read_word[`STS_TABLE_STATUS_BIT] = table_status; // see [RULE_07]
      read_word[`STS_NEGOTIATION_BIT] = negotiating_reg; // see [RULE_09]
    end else if (sel_capability) begin
      read_word[`CAP_ARB_CAP_MSB:`CAP_ARB_CAP_LSB] = arb_cap_reg;
      read_word[`CAP_ADV_SWITCH_BIT] = 1'b0; // see [RULE_12]
      read_word[`CAP_REJECT_SNOOP_BIT] = 1'b0; // see [RULE_12]
      read_word[`CAP_SLOTS_MSB:`CAP_SLOTS_LSB] = slots_reg;
      read_word[`CAP_TABLE_OFS_MSB:`CAP_TABLE_OFS_LSB] = table_ofs_reg;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @* begin
    rdata_next = 32'h0000_0000;
    if (I_RD) begin
      rdata_next = read_word;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= rdata_next;
    end
  end

  // Live configuration toward the arbiter
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_CLASS_TO_CHANNEL_MAP <= `RST_MAP;
      O_ARB_SELECT <= `RST_ARB_SEL;
      O_CHANNEL_ENABLE <= `RST_ENABLE;
      O_TABLE_APPLY <= 1'b0;
    end else begin
      O_CLASS_TO_CHANNEL_MAP <= map_next; // see [RULE_01]
      O_ARB_SELECT <= arb_sel_next; // see [RULE_04]
      O_CHANNEL_ENABLE <= enable_next; // see [RULE_06]
      O_TABLE_APPLY <= load_write; // see [RULE_03]
    end
  end

endmodule
`default_nettype wire

/* vc_resource_defs.vh */
// Constants for the channel resource configuration registers.
// Assumes 12-bit byte addresses on a plain register port.
`ifndef VC_RESOURCE_DEFS_VH
`define VC_RESOURCE_DEFS_VH

// Byte addresses
`define OFS_CH0_CONTROL 12'h154
`define OFS_CH0_STATUS 12'h158
`define OFS_CH1_CAPABILITY 12'h15c

// Channel 0 control fields
`define CTL_MAP_MSB 7
`define CTL_MAP_LSB 0
`define CTL_TABLE_LOAD_BIT 16
`define CTL_ARB_SEL_MSB 19
`define CTL_ARB_SEL_LSB 17
`define CTL_CHAN_ID_MSB 26
`define CTL_CHAN_ID_LSB 24
`define CTL_ENABLE_BIT 31

// Channel 0 status fields
`define STS_TABLE_STATUS_BIT 16
`define STS_NEGOTIATION_BIT 17

// Channel 1 capability fields
`define CAP_ARB_CAP_MSB 7
`define CAP_ARB_CAP_LSB 0
`define CAP_ADV_SWITCH_BIT 14
`define CAP_REJECT_SNOOP_BIT 15
`define CAP_SLOTS_MSB 22
`define CAP_SLOTS_LSB 16
`define CAP_TABLE_OFS_MSB 31
`define CAP_TABLE_OFS_LSB 24

// Reset values
`define RST_MAP 8'hff
`define RST_ARB_SEL 3'h0
`define RST_CHAN_ID 3'h0
`define RST_ENABLE 1'h1
`define RST_ARB_CAP_PRESENT 8'h19
`define RST_ARB_CAP_ABSENT 8'h00
`define RST_SLOTS_PRESENT 7'h7f
`define RST_SLOTS_ABSENT 7'h00
`define RST_TABLE_OFS_PRESENT 8'h08
`define RST_TABLE_OFS_ABSENT 8'h00

// Port arbitration scheme codes
`define ARB_HW_FIXED 3'h0
`define ARB_WRR_128 3'h3
`define ARB_TIME_WRR_128 3'h4

// Phases in a weighted round robin table
`define ARB_PHASES 128

`endif

/* arb_select_filter.v */
// Port arbitration select filter: maps unsupported codes to the default.
// Assumes the code comes straight from a software-written field.
`timescale 1ns/1ps
`default_nettype none
`include "vc_resource_defs.vh"

module arb_select_filter #(
  parameter ALLOW_TIME_BASED = 0
) (
  input wire [2:0] i_code,
  output reg [2:0] o_code
);

  always @* begin
    case (i_code)
      `ARB_HW_FIXED: o_code = `ARB_HW_FIXED;
      `ARB_WRR_128: o_code = `ARB_WRR_128;
      // Time-based scheme only on the second channel
      `ARB_TIME_WRR_128: begin // see [RULE_11]
        if (ALLOW_TIME_BASED != 0) begin
          o_code = `ARB_TIME_WRR_128;
        end else begin
          o_code = `ARB_HW_FIXED;
        end
      end
      default: o_code = `ARB_HW_FIXED; // see [RULE_04]
    endcase
  end

endmodule
`default_nettype wire

/* arb_table_loader.v */
// Port arbitration table loader: tracks the table status and walks the
// phases into the arbiter. Assumes all inputs are on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "vc_resource_defs.vh"

module arb_table_loader #(
  parameter PHASES = `ARB_PHASES,
  parameter IDX_W = 7
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_entry_wr,
  input wire i_load_req,
  output reg o_status,
  output reg o_busy,
  output reg o_phase_strobe,
  output reg [IDX_W-1:0] o_phase_index
);

  localparam [31:0] LAST_PHASE_WIDE = PHASES - 1;
  localparam [IDX_W-1:0] LAST_PHASE = LAST_PHASE_WIDE[IDX_W-1:0];

  wire finish;

  assign finish = o_busy && (o_phase_index == LAST_PHASE);

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_status <= 1'b0;
      o_busy <= 1'b0;
      o_phase_strobe <= 1'b0;
      o_phase_index <= {IDX_W{1'b0}};
    end else begin
      // A table write in the finishing cycle keeps the status set
      if (i_entry_wr) begin
        o_status <= 1'b1; // see [RULE_07]
      end else if (finish) begin
        o_status <= 1'b0; // see [RULE_08]
      end
      if (finish) begin
        o_busy <= 1'b0;
        o_phase_strobe <= 1'b0;
        o_phase_index <= {IDX_W{1'b0}};
      end else if (o_busy) begin
        o_phase_index <= o_phase_index + {{(IDX_W-1){1'b0}}, 1'b1};
      end else if (i_load_req) begin
        // One phase per cycle through the whole table
        o_busy <= 1'b1; // see [RULE_11]
        o_phase_strobe <= 1'b1;
        o_phase_index <= {IDX_W{1'b0}};
      end
    end
  end

endmodule
`default_nettype wire

/* vc_resource_config_regs_chk.sv */
// Checker for the channel resource configuration registers.
// Assumes it is bound to vc_resource_config_regs on the core clock.
`timescale 1ns/1ps
`default_nettype none
module vc_resource_config_regs_chk #(
  parameter ADDR_W = 12,
  parameter PHASE_IDX_W = 7
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic I_CHANNEL1_PRESENT,
  input wire logic I_AUTOLOAD_VALID,
  input wire logic [7:0] I_AUTOLOAD_MAP,
  input wire logic [6:0] I_AUTOLOAD_SLOTS,
  input wire logic I_TABLE_ENTRY_WR,
  input wire logic I_NEGOTIATING,
  input wire logic [7:0] O_CLASS_TO_CHANNEL_MAP,
  input wire logic [2:0] O_ARB_SELECT,
  input wire logic O_CHANNEL_ENABLE,
  input wire logic O_TABLE_APPLY,
  input wire logic O_TABLE_BUSY,
  input wire logic O_PHASE_STROBE,
  input wire logic [PHASE_IDX_W-1:0] O_PHASE_INDEX
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);
  sequence ctl_wr;
    I_WR && I_ADDR == 12'h154;
  endsequence
  sequence walk_last;
    O_TABLE_BUSY && O_PHASE_INDEX == {PHASE_IDX_W{1'b1}};
  endsequence
  sequence walk_mid;
    O_TABLE_BUSY && O_PHASE_INDEX != {PHASE_IDX_W{1'b1}};
  endsequence
  sequence walk_start;
    O_TABLE_APPLY && !O_TABLE_BUSY;
  endsequence
  AST_MAP_WR: assert property (ctl_wr |=>
    O_CLASS_TO_CHANNEL_MAP == $past(I_WDATA[7:0])) else $error("map");
  AST_SEL_WR: assert property (ctl_wr |=> O_ARB_SELECT ==
    ($past(I_WDATA[19:17]) == 3'h3 ? 3'h3 : 3'h0)) else $error("select");
  AST_EN_WR: assert property (ctl_wr |=>
    O_CHANNEL_ENABLE == $past(I_WDATA[31])) else $error("enable");
  AST_AUTO: assert property (I_AUTOLOAD_VALID &&
    !(I_WR && I_ADDR == 12'h154) |=>
    O_CLASS_TO_CHANNEL_MAP == $past(I_AUTOLOAD_MAP)) else $error("autoload");
  AST_APPLY: assert property (O_TABLE_APPLY ==
    $past(I_WR && I_ADDR == 12'h154 && I_WDATA[16])) else $error("apply");
  AST_START: assert property (walk_start |=>
    O_TABLE_BUSY && O_PHASE_STROBE && O_PHASE_INDEX == 0)
    else $error("start");
  AST_STEP: assert property (walk_mid |=> O_TABLE_BUSY &&
    O_PHASE_INDEX == $past(O_PHASE_INDEX) + 1'b1) else $error("step");
  AST_END: assert property (walk_last |=>
    !O_TABLE_BUSY && !O_PHASE_STROBE) else $error("end");
  AST_RD_IDLE: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("rdata idle");
  AST_CTL_RD: assert property (I_RD && I_ADDR == 12'h154 |=>
    (O_RDATA & 32'h7ff1ff00) == 0 && O_RDATA[7:0] ==
    $past(O_CLASS_TO_CHANNEL_MAP)) else $error("control read");
  AST_CAP_RD: assert property (I_RD && I_ADDR == 12'h15c |=>
    (O_RDATA & 32'h0080ff00) == 0) else $error("capability read");
endmodule
bind vc_resource_config_regs vc_resource_config_regs_chk #(
  .ADDR_W(ADDR_W), .PHASE_IDX_W(PHASE_IDX_W)) chk_u (.*);
`default_nettype wire

/* tb_top.sv */
// Testbench for the channel resource configuration registers.
// Assumes the design and its checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, srst = 1, wr = 0, rd = 0, pres = 1, alv = 0;
  logic ent = 0, neg = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0;
  logic [7:0] amap = 0;
  logic [6:0] aslot = 0;
  wire [31:0] rdata;
  wire [7:0] map;
  wire [2:0] sel;
  wire en, apply, busy, strobe;
  wire [6:0] idx;
  int fails = 0;
  int num_checks = 0;
  vc_resource_config_regs dut_u (.I_CORE_CLK(clk), .I_SRST(srst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_CHANNEL1_PRESENT(pres), .I_AUTOLOAD_VALID(alv),
    .I_AUTOLOAD_MAP(amap), .I_AUTOLOAD_SLOTS(aslot),
    .I_TABLE_ENTRY_WR(ent), .I_NEGOTIATING(neg),
    .O_CLASS_TO_CHANNEL_MAP(map), .O_ARB_SELECT(sel),
    .O_CHANNEL_ENABLE(en), .O_TABLE_APPLY(apply), .O_TABLE_BUSY(busy),
    .O_PHASE_STROBE(strobe), .O_PHASE_INDEX(idx));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk);
    pres <= p;
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
  endtask
  task automatic t_reset;
    rd_chk(12'h154, 32'h800000ff);
    rd_chk(12'h158, 32'h0);
    rd_chk(12'h15c, 32'h087f0019);
    rd_chk(12'h200, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_ctl;
    wr_reg(12'h154, 32'hfffeff06);
    rd_chk(12'h154, 32'h80000006);
    chk({20'h0, sel, en, map}, 32'h00000106);
    for (int c = 0; c < 8; c++) begin
      wr_reg(12'h154, {12'h0, c[2:0], 17'h0});
      rd_chk(12'h154, (c == 3) ? 32'h00060000 : 32'h0);
    end
    $display("control test done");
  endtask
  task automatic t_table;
    logic [31:0] n;
    n = 0;
    @(posedge clk);
    ent <= 1;
    @(posedge clk);
    ent <= 0;
    rd_chk(12'h158, 32'h00010000);
    wr_reg(12'h158, 32'hffffffff);
    rd_chk(12'h158, 32'h00010000);
    wr_reg(12'h154, 32'h800100ff);
    for (int k = 0; k < 300; k++) begin
      @(posedge clk);
      #1 n += busy;
    end
    chk(n, 32'd128);
    rd_chk(12'h154, 32'h800000ff);
    rd_chk(12'h158, 32'h0);
    @(posedge clk);
    neg <= 1;
    repeat (4) @(posedge clk);
    rd_chk(12'h158, 32'h00020000);
    @(posedge clk);
    neg <= 0;
    repeat (4) @(posedge clk);
    rd_chk(12'h158, 32'h0);
    $display("table test done");
  endtask
  task automatic t_auto;
    @(posedge clk);
    alv <= 1;
    amap <= 8'h5a;
    aslot <= 7'h33;
    @(posedge clk);
    alv <= 0;
    rd_chk(12'h154, 32'h8000005a);
    rd_chk(12'h15c, 32'h08330019);
    wr_reg(12'h15c, 32'hffffffff);
    rd_chk(12'h15c, 32'h08330019);
    do_reset(1'b0);
    rd_chk(12'h15c, 32'h0);
    rd_chk(12'h154, 32'h800000ff);
    $display("autoload test done");
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    t_reset;
    t_ctl;
    t_table;
    t_auto;
    conclude;
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude;
  end
endmodule
`default_nettype wire
